/* hdl/lbrg_top.sv */
`timescale 1ns/1ps
// Summary of operation
// - two lines, high-priority line wins ties
// - grant pulse on same line in T4/T1
// - bus floated, hold-acknowledge next clock
// - no bus activity during hold-acknowledge
// - release pulse returns bus next clock
// - exchange is request, grant, release pulses
// - one dead clock after each exchange
// - all pulses driven low, idle high
// - mid-cycle release of a memory cycle needs request by T2
// - no mid-cycle release of a memory cycle on odd low byte
// - no mid-cycle release of a memory cycle on first interrupt ack
// - no mid-cycle release of a memory cycle during locked instruction
// - otherwise release when cycle completes
// - idle bus released on next clock
// - cycle may start, request timing counts met
module lbrg_top (
    input  wire logic       CLK,
    input  wire logic       RESET_N,
    input  wire logic       BUS_REQ_GRANT_HIGH_PRIO_IN,
    output logic            BUS_REQ_GRANT_HIGH_PRIO_OUT,
    output logic            BUS_REQ_GRANT_HIGH_PRIO_OE,
    input  wire logic       BUS_REQ_GRANT_LOW_PRIO_IN,
    output logic            BUS_REQ_GRANT_LOW_PRIO_OUT,
    output logic            BUS_REQ_GRANT_LOW_PRIO_OE,
    input  wire logic [2:0] T_STATE,
    input  wire logic       CYCLE_ACTIVE,
    input  wire logic       CYCLE_IS_MEM,
    input  wire logic       ODD_LOW_BYTE,
    input  wire logic       FIRST_INTA,
    input  wire logic       LOCK_ACTIVE,
    output logic            HOLD_ACK,
    output logic            BUS_FLOAT,
    output logic            START_INHIBIT
);
    import lbrg_pkg::*;

    lbrg_state_t state_q;
    lbrg_state_t state_d;
    logic        sel_q;
    logic        sel_d;
    logic        early_q;
    logic        early_d;
    logic        hold_q;
    logic        hold_d;
    logic        float_q;
    logic        float_d;
    logic        pulse_hi;
    logic        pulse_lo;
    logic        grant_now;
    logic        grant_hi;
    logic        grant_lo;
    logic        pulse_sel;
    logic        by_t2;
    logic        mid_ok;

    lbrg_line u_line_hi (
        .clk     (CLK),
        .reset_n (RESET_N),
        .line_in (BUS_REQ_GRANT_HIGH_PRIO_IN),
        .grant   (grant_hi),
        .pulse   (pulse_hi),
        .line_out(BUS_REQ_GRANT_HIGH_PRIO_OUT),
        .line_oe (BUS_REQ_GRANT_HIGH_PRIO_OE)
    );

    lbrg_line u_line_lo (
        .clk     (CLK),
        .reset_n (RESET_N),
        .line_in (BUS_REQ_GRANT_LOW_PRIO_IN),
        .grant   (grant_lo),
        .pulse   (pulse_lo),
        .line_out(BUS_REQ_GRANT_LOW_PRIO_OUT),
        .line_oe (BUS_REQ_GRANT_LOW_PRIO_OE)
    );

    // request seen while no cycle runs or no later than T2
    assign by_t2 = !CYCLE_ACTIVE || (T_STATE == TS_IDLE)
                   || (T_STATE == TS_T1) || (T_STATE == TS_T2);

    // i/o and other non-memory cycles release at their own end
    assign mid_ok = !CYCLE_IS_MEM
                    || (early_q
                        && !ODD_LOW_BYTE
                        && !FIRST_INTA
                        && !LOCK_ACTIVE);

    always_comb begin
        grant_now = 1'b0;
        if (state_q == ARB_PENDING) begin
            if (!CYCLE_ACTIVE) begin
                grant_now = 1'b1;
            end else if (T_STATE == TS_T4) begin
                grant_now = mid_ok;
            end
        end
    end

    assign grant_hi  = grant_now && (sel_q == SEL_HIGH);
    assign grant_lo  = grant_now && (sel_q == SEL_LOW);
    assign pulse_sel = (sel_q == SEL_HIGH) ? pulse_hi : pulse_lo;

    always_comb begin
        state_d = state_q;
        sel_d   = sel_q;
        early_d = early_q;
        hold_d  = hold_q;
        float_d = float_q;
        case (state_q)
            ARB_IDLE: begin
                if (pulse_hi || pulse_lo) begin
                    state_d = ARB_PENDING;
                    sel_d   = pulse_hi ? SEL_HIGH : SEL_LOW;
                    early_d = by_t2;
                end
            end
            ARB_PENDING: begin
                if (grant_now) begin
                    state_d = ARB_HOLD;
                    hold_d  = 1'b1;
                    float_d = 1'b1;
                end else if (CYCLE_ACTIVE && T_STATE == TS_T4) begin
                    // withheld now: the next cycle sees the request early
                    early_d = 1'b1;
                end
            end
            ARB_HOLD: begin
                if (pulse_sel) begin
                    state_d = ARB_DEAD;
                    hold_d  = 1'b0;
                    float_d = 1'b0;
                end
            end
            ARB_DEAD: begin
                // pulses during the dead clock are dropped
                state_d = ARB_IDLE;
                early_d = 1'b0;
            end
            default: begin
                state_d = ARB_IDLE;
                hold_d  = 1'b0;
                float_d = 1'b0;
                early_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_q <= ARB_IDLE;
            sel_q   <= SEL_HIGH;
            early_q <= 1'b0;
            hold_q  <= 1'b0;
            float_q <= 1'b0;
        end else begin
            state_q <= state_d;
            sel_q   <= sel_d;
            early_q <= early_d;
            hold_q  <= hold_d;
            float_q <= float_d;
        end
    end

    assign HOLD_ACK      = hold_q;
    // drivers float already in the grant clock
    assign BUS_FLOAT     = float_q || grant_now;
    assign START_INHIBIT = float_q || grant_now;

    property p_grant_one_clk;
        @(posedge CLK) disable iff (!RESET_N)
        (BUS_REQ_GRANT_HIGH_PRIO_OE || BUS_REQ_GRANT_LOW_PRIO_OE)
        |=> !BUS_REQ_GRANT_HIGH_PRIO_OE && !BUS_REQ_GRANT_LOW_PRIO_OE;
    endproperty
    a_grant_one_clk: assert property (p_grant_one_clk)
        else $error("grant pulse longer than one clock");

    property p_hold_after_grant;
        @(posedge CLK) disable iff (!RESET_N)
        grant_now |=> HOLD_ACK && BUS_FLOAT;
    endproperty
    a_hold_after_grant: assert property (p_hold_after_grant)
        else $error("no hold-acknowledge after grant");

    property p_no_start_in_hold;
        @(posedge CLK) disable iff (!RESET_N)
        HOLD_ACK |-> START_INHIBIT;
    endproperty
    a_no_start_in_hold: assert property (p_no_start_in_hold)
        else $error("bus activity allowed in hold-acknowledge");

    property p_release;
        @(posedge CLK) disable iff (!RESET_N)
        (state_q == ARB_HOLD && pulse_sel) |=> !HOLD_ACK ##1
        (state_q == ARB_IDLE);
    endproperty
    a_release: assert property (p_release)
        else $error("release pulse did not return the bus");

    property p_dead_cycle;
        @(posedge CLK) disable iff (!RESET_N)
        $fell(HOLD_ACK) |-> !grant_now ##1 !grant_now;
    endproperty
    a_dead_cycle: assert property (p_dead_cycle)
        else $error("line reused without a dead clock");

    property p_priority;
        @(posedge CLK) disable iff (!RESET_N)
        (state_q == ARB_IDLE && pulse_hi && pulse_lo) |=> sel_q == SEL_HIGH;
    endproperty
    a_priority: assert property (p_priority)
        else $error("low-priority line won a tie");

    property p_withhold;
        @(posedge CLK) disable iff (!RESET_N)
        (CYCLE_ACTIVE && CYCLE_IS_MEM
         && (ODD_LOW_BYTE || FIRST_INTA || LOCK_ACTIVE)) |-> !grant_now;
    endproperty
    a_withhold: assert property (p_withhold)
        else $error("mid-cycle release not withheld");

    property p_idle_release;
        @(posedge CLK) disable iff (!RESET_N)
        (state_q == ARB_IDLE && (pulse_hi || pulse_lo))
        ##1 !CYCLE_ACTIVE |-> grant_now;
    endproperty
    a_idle_release: assert property (p_idle_release)
        else $error("idle bus not released next clock");

    property p_oe_only_grant;
        @(posedge CLK) disable iff (!RESET_N)
        BUS_REQ_GRANT_HIGH_PRIO_OE |-> state_q == ARB_PENDING
        && BUS_REQ_GRANT_HIGH_PRIO_OUT == LINE_ACTIVE;
    endproperty
    a_oe_only_grant: assert property (p_oe_only_grant)
        else $error("line driven outside grant pulse");
endmodule

/* hdl/lbrg_pkg.sv */
package lbrg_pkg;
    // bus state codes presented by the bus interface unit
    localparam logic [2:0] TS_IDLE = 3'h0;
    localparam logic [2:0] TS_T1   = 3'h1;
    localparam logic [2:0] TS_T2   = 3'h2;
    localparam logic [2:0] TS_T3   = 3'h3;
    localparam logic [2:0] TS_T4   = 3'h4;
    localparam logic [2:0] TS_TW   = 3'h5;

    // level driven during any pulse; the line idles high
    localparam logic LINE_ACTIVE = 1'h0;
    localparam logic LINE_IDLE   = 1'h1;

    localparam logic SEL_HIGH = 1'h0;
    localparam logic SEL_LOW  = 1'h1;

    typedef enum logic [1:0] {
        ARB_IDLE,
        ARB_PENDING,
        ARB_HOLD,
        ARB_DEAD
    } lbrg_state_t;
endpackage

/* hdl/lbrg_line.sv */
`timescale 1ns/1ps
module lbrg_line (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic line_in,
    input  wire logic grant,
    output logic      pulse,
    output logic      line_out,
    output logic      line_oe
);
    import lbrg_pkg::*;

    logic prev_high_q;
    logic prev_high_d;

    // our own drive counts as high so a release pulse right after the
    // grant pulse is still seen as a fresh falling edge
    always_comb begin
        prev_high_d = line_in | grant;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_high_q <= LINE_IDLE;
        end else begin
            prev_high_q <= prev_high_d;
        end
    end

    assign pulse    = (line_in == LINE_ACTIVE) && prev_high_q && !grant;
    assign line_out = LINE_ACTIVE;
    assign line_oe  = grant;
endmodule

/* verif/lbrg_master_model.sv */
`timescale 1ns/1ps
module lbrg_master_model (
    input  wire logic clk,
    output logic      drv
);
    initial drv = 1'b0;
    // one clock of low drive, then the line is left to the pull-up
    task automatic pulse();
        @(negedge clk);
        drv = 1'b1;
        @(negedge clk);
        drv = 1'b0;
    endtask
endmodule

/* verif/tb_local_bus_request_grant.sv */
`timescale 1ns/1ps
module tb_local_bus_request_grant;
    import lbrg_pkg::*;
    logic       clk;
    logic       reset_n;
    logic       hi_out, hi_oe, lo_out, lo_oe;
    logic       hold_ack, bus_float, start_inhibit;
    logic [2:0] t_state;
    logic       cyc, mem, odd, inta, lock;
    logic       p0_drv, p1_drv;
    wire logic  hi_line = (hi_oe ? hi_out : 1'b1) & ~p0_drv;
    wire logic  lo_line = (lo_oe ? lo_out : 1'b1) & ~p1_drv;
    int         n_errors;
    int         n_compared;

    lbrg_top DUT (
        .CLK                         (clk),
        .RESET_N                     (reset_n),
        .BUS_REQ_GRANT_HIGH_PRIO_IN  (hi_line),
        .BUS_REQ_GRANT_HIGH_PRIO_OUT (hi_out),
        .BUS_REQ_GRANT_HIGH_PRIO_OE  (hi_oe),
        .BUS_REQ_GRANT_LOW_PRIO_IN   (lo_line),
        .BUS_REQ_GRANT_LOW_PRIO_OUT  (lo_out),
        .BUS_REQ_GRANT_LOW_PRIO_OE   (lo_oe),
        .T_STATE                     (t_state),
        .CYCLE_ACTIVE                (cyc),
        .CYCLE_IS_MEM                (mem),
        .ODD_LOW_BYTE                (odd),
        .FIRST_INTA                  (inta),
        .LOCK_ACTIVE                 (lock),
        .HOLD_ACK                    (hold_ack),
        .BUS_FLOAT                   (bus_float),
        .START_INHIBIT               (start_inhibit)
    );
    lbrg_master_model p0 (.clk(clk), .drv(p0_drv));
    lbrg_master_model p1 (.clk(clk), .drv(p1_drv));

    initial clk = 1'b0;
    always #5 clk = ~clk;

    task automatic chk(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic idle_bus_exchange();
        p0.pulse();
        chk(hi_oe, 1'b1);
        chk(hi_out, LINE_ACTIVE);
        chk(bus_float, 1'b1);
        @(negedge clk);
        chk(hi_oe, 1'b0);
        chk(hold_ack, 1'b1);
        chk(start_inhibit, 1'b1);
        p0.pulse();
        chk(hold_ack, 1'b0);
        chk(bus_float, 1'b0);
    endtask

    task automatic tie_and_low_line();
        fork
            p0.pulse();
            p1.pulse();
        join
        chk(hi_oe, 1'b1);
        chk(lo_oe, 1'b0);
        @(negedge clk);
        p1.pulse();
        chk(lo_oe, 1'b0);
        chk(hold_ack, 1'b1);
        p0.pulse();
        chk(hold_ack, 1'b0);
        @(negedge clk);
        p1.pulse();
        chk(lo_oe, 1'b1);
        @(negedge clk);
        chk(hold_ack, 1'b1);
        p1.pulse();
        chk(hold_ack, 1'b0);
    endtask

    // three withheld cycles, then a clean one that must release at T4
    task automatic mem_cycle_release();
        logic [2:0] ts;
        cyc = 1'b1;
        mem = 1'b1;
        fork
            p0.pulse();
        join_none
        for (int i = 0; i < 4; i++) begin
            for (int s = 1; s <= 4; s++) begin
                ts = 3'(s);
                @(negedge clk);
                t_state = ts;
                odd  = (i == 0);
                inta = (i == 1);
                lock = (i == 2);
                #1;
                chk(hi_oe, (i == 3) && (ts == TS_T4));
            end
        end
        @(negedge clk);
        cyc     = 1'b0;
        t_state = TS_IDLE;
        chk(hold_ack, 1'b1);
        p0.pulse();
        chk(hold_ack, 1'b0);
    endtask

    // request lands in T3: a memory cycle must wait for the next T4,
    // a non-memory cycle gives the bus up at its own T4
    task automatic late_request(input logic is_mem, input logic use_lo);
        int last;
        last = is_mem ? 8 : 4;
        cyc  = 1'b1;
        mem  = is_mem;
        lock = !is_mem;
        fork
            for (int s = 1; s <= last; s++) begin
                @(negedge clk);
                t_state = 3'((s - 1) % 4 + 1);
                #1;
                chk(use_lo ? lo_oe : hi_oe, s == last);
                chk(start_inhibit, s == last);
            end
            begin
                repeat (2) @(negedge clk);
                if (use_lo)
                    p1.pulse();
                else
                    p0.pulse();
            end
        join
        chk(use_lo ? lo_out : hi_out, LINE_ACTIVE);
        @(negedge clk);
        cyc     = 1'b0;
        t_state = TS_IDLE;
        lock    = 1'b0;
        chk(hold_ack, 1'b1);
        if (use_lo)
            p1.pulse();
        else
            p0.pulse();
        chk(hold_ack, 1'b0);
    endtask

    // reset taken in hold-acknowledge must hand the bus back at once
    task automatic reset_in_hold();
        p0.pulse();
        @(negedge clk);
        chk(hold_ack, 1'b1);
        reset_n = 1'b0;
        #1;
        chk(hold_ack, 1'b0);
        chk(bus_float, 1'b0);
        chk(hi_oe, 1'b0);
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        idle_bus_exchange();
    endtask

    initial begin
        n_errors   = 0;
        n_compared = 0;
        reset_n    = 1'b0;
        t_state    = TS_IDLE;
        {cyc, mem, odd, inta, lock} = 5'h00;
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        chk(hold_ack, 1'b0);
        idle_bus_exchange();
        tie_and_low_line();
        mem_cycle_release();
        late_request(1'b1, 1'b0);
        late_request(1'b0, 1'b1);
        reset_in_hold();
        repeat (2) @(negedge clk);
        print_verdict();
    end

    initial begin
        #20000;
        n_errors++;
        print_verdict();
    end
endmodule
